/* File: hw/rsi_regs.vh */
`ifndef RSI_REGS_VH
`define RSI_REGS_VH
// apb byte offsets
`define RSI_OFF_STATUS    12'h000
`define RSI_OFF_RFLAG     12'h004
`define RSI_OFF_CTRL      12'h008
`define RSI_OFF_IRQ_STAT  12'h00C
`define RSI_OFF_IRQ_MASK  12'h010
`define RSI_OFF_CAUSE     12'h014
// status register fields
`define RSI_BIT_PDF       1
`define RSI_BIT_TOF       0
// reset flag register fields
`define RSI_BIT_LOW_VOLTAGE_RESET_FLAG      2
// control register fields
`define RSI_BIT_INT_EN    0
`define RSI_BIT_TMR_ON    1
`define RSI_BIT_IO_OUT    2
// irq status fields, one per reset class
`define RSI_IRQ_POR       0
`define RSI_IRQ_LVR       1
`define RSI_IRQ_WDT_RUN   2
`define RSI_IRQ_WDT_LP    3
// cause codes
`define RSI_CAUSE_NONE    3'h0
`define RSI_CAUSE_POR     3'h1
`define RSI_CAUSE_LVR     3'h2
`define RSI_CAUSE_WDT_RUN 3'h3
`define RSI_CAUSE_WDT_LP  3'h4
// reset values
`define RSI_RST_PC        16'h0000
`define RSI_RST_MASK      4'h0
`endif

/* File: hw/rsi_classify.v */
`default_nettype none
module rsi_classify (
    // reset sources
    input  wire       por_event,
    input  wire       lvr_event,
    input  wire       wdt_event,
    // mode at the time
    input  wire       low_power_mode,
    // class
    output reg  [2:0] cause
);
`include "rsi_regs.vh"
    // power-on outranks low-voltage, which outranks watchdog
    always @* begin
        if (por_event) begin
            cause = `RSI_CAUSE_POR;
        end else if (lvr_event && !low_power_mode) begin
            cause = `RSI_CAUSE_LVR;
        end else if (wdt_event && low_power_mode) begin
            cause = `RSI_CAUSE_WDT_LP;
        end else if (wdt_event) begin
            cause = `RSI_CAUSE_WDT_RUN;
        end else begin
            cause = `RSI_CAUSE_NONE;
        end
    end
endmodule // rsi_classify
`default_nettype wire

/* File: hw/rsi_top.v */
// The placing of the registers and register access over APB are this design's own decisions.
`default_nettype none
module rsi_top #(
    parameter PC_W     = 16,
    parameter SP_W     = 3,
    parameter IO_W     = 16,
    parameter WDT_W    = 16,
    parameter TB_W     = 16,
    parameter LVR_QUAL = 4
) (
    // apb
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    // reset sources, synchronous to pclk
    input  wire              por_req,
    input  wire              lvr_low,
    input  wire              wdt_overflow,
    input  wire              low_power_mode,
    input  wire              wdt_clear,
    // to the core and peripherals
    output reg               core_reset,
    output reg  [PC_W-1:0]   pc_init,
    output reg  [SP_W-1:0]   sp_init,
    output reg               int_enable,
    output reg               timer_on,
    output reg  [IO_W-1:0]   io_dir_out,
    output reg  [WDT_W-1:0]  wdt_count,
    output reg  [TB_W-1:0]   tb_count,
    output reg               irq
);
`include "rsi_regs.vh"
    localparam ST_RUN   = 2'h0;
    localparam ST_RESET = 2'h1;
    localparam QW       = 4;

    reg  [1:0]  state_reg;
    reg  [2:0]  pend_reg;
    reg  [QW-1:0] lvr_cnt_reg;
    reg         lvr_seen_reg;
    reg         tof_reg;
    reg         pdf_reg;
    reg         low_voltage_reset_flag_reg;
    reg  [3:0]  irq_stat_reg;
    reg  [3:0]  irq_mask_reg;
    reg  [2:0]  last_cause_reg;
    reg         por_pend_reg;
    wire [2:0]  cause;
    wire        lvr_qual;
    wire        wr;
    wire        rd;
    reg  [3:0]  irq_set;
    reg  [31:0] rd_mux;

    // low-voltage needs LVR_QUAL consecutive low cycles; ignored in low-power modes
    assign lvr_qual = lvr_low && !low_power_mode && (lvr_cnt_reg == LVR_QUAL[QW-1:0] - 4'h1)
                      && !lvr_seen_reg;
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    rsi_classify u_cls (
        .por_event      (por_pend_reg),
        .lvr_event      (lvr_qual),
        .wdt_event      (wdt_overflow),
        .low_power_mode (low_power_mode),
        .cause          (cause)
    );

    function [3:0] cause_bit;
        input [2:0] c;
        begin
            case (c)
                `RSI_CAUSE_POR:     cause_bit = 4'h1;
                `RSI_CAUSE_LVR:     cause_bit = 4'h2;
                `RSI_CAUSE_WDT_RUN: cause_bit = 4'h4;
                `RSI_CAUSE_WDT_LP:  cause_bit = 4'h8;
                default:            cause_bit = 4'h0;
            endcase
        end
    endfunction

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvr_cnt_reg  <= {QW{1'b0}};
            lvr_seen_reg <= 1'b0;
        end else if (!lvr_low || low_power_mode) begin
            lvr_cnt_reg  <= {QW{1'b0}};
            lvr_seen_reg <= 1'b0;
        end else if (lvr_cnt_reg != LVR_QUAL[QW-1:0] - 4'h1) begin
            lvr_cnt_reg <= lvr_cnt_reg + 4'h1;
        end else begin
            lvr_seen_reg <= 1'b1;
        end
    end

    // state machine: one cycle of core reset per event, flags applied at release
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= ST_RESET;
            pend_reg     <= `RSI_CAUSE_POR;
            por_pend_reg <= 1'b1;
            core_reset   <= 1'b1;
        end else begin
            por_pend_reg <= por_req;
            case (state_reg)
                ST_RUN: begin
                    if (cause != `RSI_CAUSE_NONE) begin
                        state_reg  <= ST_RESET;
                        pend_reg   <= cause;
                        core_reset <= 1'b1;
                    end
                end
                ST_RESET: begin
                    state_reg  <= ST_RUN;
                    core_reset <= 1'b0;
                end
                default: begin
                    state_reg  <= ST_RUN;
                    core_reset <= 1'b0;
                end
            endcase
        end
    end

    wire release_now = (state_reg == ST_RESET);
    wire full_reset  = release_now && (pend_reg != `RSI_CAUSE_WDT_LP);

    // flags updated in the release cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tof_reg        <= 1'b0;
            pdf_reg        <= 1'b0;
            last_cause_reg <= `RSI_CAUSE_NONE;
        end else if (release_now) begin
            last_cause_reg <= pend_reg;
            case (pend_reg)
                `RSI_CAUSE_POR: begin
                    tof_reg <= 1'b0;
                    pdf_reg <= 1'b0;
                end
                `RSI_CAUSE_WDT_RUN: begin
                    tof_reg <= 1'b1;
                end
                `RSI_CAUSE_WDT_LP: begin
                    tof_reg <= 1'b1;
                    pdf_reg <= 1'b1;
                end
                default: begin
                    tof_reg <= tof_reg;
                end
            endcase
        end
    end

    // core and peripheral initial state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_init    <= {PC_W{1'b0}};
            sp_init    <= {SP_W{1'b0}};
            int_enable <= 1'b0;
            timer_on   <= 1'b0;
            io_dir_out <= {IO_W{1'b0}};
            wdt_count  <= {WDT_W{1'b0}};
            tb_count   <= {TB_W{1'b0}};
        end else begin
            if (release_now) begin
                pc_init <= `RSI_RST_PC;
                sp_init <= {SP_W{1'b0}};
            end
            if (full_reset) begin
                int_enable <= 1'b0;
                timer_on   <= 1'b0;
                io_dir_out <= {IO_W{1'b0}};
            end else if (wr && paddr == `RSI_OFF_CTRL) begin
                int_enable <= pwdata[`RSI_BIT_INT_EN];
                timer_on   <= pwdata[`RSI_BIT_TMR_ON];
                io_dir_out <= {IO_W{pwdata[`RSI_BIT_IO_OUT]}};
            end
            // counters restart from zero on every reset but a low-power watchdog one, and run with no software action
            if (full_reset || wdt_clear) begin
                wdt_count <= {WDT_W{1'b0}};
            end else begin
                wdt_count <= wdt_count + {{(WDT_W-1){1'b0}}, 1'b1};
            end
            if (full_reset) begin
                tb_count <= {TB_W{1'b0}};
            end else begin
                tb_count <= tb_count + {{(TB_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // low-voltage flag and event interrupts: set wins over clear
    always @* begin
        irq_set = release_now ? cause_bit(pend_reg) : 4'h0;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_voltage_reset_flag_reg     <= 1'b0;
            irq_stat_reg <= 4'h0;
            irq_mask_reg <= `RSI_RST_MASK;
        end else begin
            if (release_now && pend_reg == `RSI_CAUSE_LVR) begin
                low_voltage_reset_flag_reg <= 1'b1;
            end else if (wr && paddr == `RSI_OFF_RFLAG) begin
                low_voltage_reset_flag_reg <= low_voltage_reset_flag_reg & pwdata[`RSI_BIT_LOW_VOLTAGE_RESET_FLAG];
            end
            if (wr && paddr == `RSI_OFF_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~pwdata[3:0]) | irq_set;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_set;
            end
            if (wr && paddr == `RSI_OFF_IRQ_MASK) begin
                irq_mask_reg <= pwdata[3:0];
            end
        end
    end

    always @* begin
        case (paddr)
            `RSI_OFF_STATUS:   rd_mux = {30'h0, pdf_reg, tof_reg};
            `RSI_OFF_RFLAG:    rd_mux = {29'h0, low_voltage_reset_flag_reg, 2'h0};
            `RSI_OFF_CTRL:     rd_mux = {29'h0, io_dir_out[0], timer_on, int_enable};
            `RSI_OFF_IRQ_STAT: rd_mux = {28'h0, irq_stat_reg};
            `RSI_OFF_IRQ_MASK: rd_mux = {28'h0, irq_mask_reg};
            `RSI_OFF_CAUSE:    rd_mux = {29'h0, last_cause_reg};
            default:           rd_mux = 32'h0;
        endcase
    end

    // zero-wait apb: data latched in setup, ready in access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            irq     <= 1'b0;
        end else begin
            if (rd) begin
                prdata <= rd_mux;
            end
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (paddr > `RSI_OFF_CAUSE || paddr[1:0] != 2'h0);
            irq     <= |((irq_stat_reg | irq_set) & irq_mask_reg);
        end
    end
endmodule // rsi_top
`default_nettype wire

/* File: verif/rsi_checker.sv */
`default_nettype none
module rsi_checker #(
    parameter PC_W  = 16,
    parameter SP_W  = 3,
    parameter IO_W  = 16,
    parameter WDT_W = 16,
    parameter TB_W  = 16
) (
    // apb
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pready,
    // reset sources
    input wire logic             por_req,
    input wire logic             lvr_low,
    input wire logic             wdt_overflow,
    input wire logic             low_power_mode,
    // to the core and peripherals
    input wire logic             core_reset,
    input wire logic             int_enable,
    input wire logic             timer_on,
    input wire logic [PC_W-1:0]  pc_init,
    input wire logic [SP_W-1:0]  sp_init,
    input wire logic [IO_W-1:0]  io_dir_out,
    input wire logic [WDT_W-1:0] wdt_count,
    input wire logic [TB_W-1:0]  tb_count
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_por;
        $rose(por_req) && !core_reset;
    endsequence
    sequence s_rel;
        ##[1:5] $fell(core_reset);
    endsequence
    property p_pc_zero;
        $fell(core_reset) |-> pc_init == '0 && sp_init == '0;
    endproperty
    a_pc_zero: assert property (p_pc_zero) else $error("start address not zero");
    property p_int_off;
        s_por |-> s_rel ##0 !int_enable;
    endproperty
    a_int_off: assert property (p_int_off) else $error("interrupts left on");
    property p_tmr_off;
        s_por |-> s_rel ##0 !timer_on;
    endproperty
    a_tmr_off: assert property (p_tmr_off) else $error("timer left on");
    property p_io_in;
        s_por |-> s_rel ##0 io_dir_out == '0;
    endproperty
    a_io_in: assert property (p_io_in) else $error("pin left as output");
    property p_cnt;
        s_por |-> s_rel ##0 (wdt_count < 2 && tb_count < 2) ##3 wdt_count != '0;
    endproperty
    a_cnt: assert property (p_cnt) else $error("counters not restarted");
    property p_lp_keep;
        wdt_overflow && low_power_mode && !core_reset && !psel
            |-> $stable({io_dir_out, int_enable, timer_on})[*6];
    endproperty
    a_lp_keep: assert property (p_lp_keep) else $error("low power reset changed state");
    property p_wdt_pulse;
        $rose(wdt_overflow) && !core_reset |-> ##[1:3] core_reset ##1 !core_reset;
    endproperty
    a_wdt_pulse: assert property (p_wdt_pulse) else $error("no reset pulse");
    property p_lvr;
        $rose(lvr_low) ##1 (lvr_low && !low_power_mode)[*3] |-> ##[0:6] core_reset;
    endproperty
    a_lvr: assert property (p_lvr) else $error("qualified low supply ignored");
    property p_apb;
        psel && !penable |=> pready && penable;
    endproperty
    a_apb: assert property (p_apb) else $error("no answer after setup");
endmodule // rsi_checker
bind rsi_top rsi_checker #(.PC_W(PC_W), .SP_W(SP_W), .IO_W(IO_W), .WDT_W(WDT_W), .TB_W(TB_W))
    u_chk (.*);
`default_nettype wire

/* File: verif/rsi_core_model.sv */
`default_nettype none
module rsi_core_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // reset from the block
    input wire logic core_reset,
    // restarts seen
    output int       resets
);
    timeunit 1ns;
    timeprecision 1ps;
    logic held;
    // a restart counts once the core leaves reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held <= 1'b1;
            resets <= 0;
        end else begin
            held <= core_reset;
            if (held && !core_reset) resets <= resets + 1;
        end
    end
endmodule // rsi_core_model
`default_nettype wire

/* File: verif/rsi_bench.sv */
`default_nettype none
`include "rsi_regs.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
    $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module reset_initial_state_logic_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, core_reset, int_enable, timer_on, irq;
    logic        por_req = 0, lvr_low = 0, wdt_overflow = 0, low_power_mode = 0;
    logic        wdt_clear = 0;
    logic [15:0] pc_init, io_dir_out, wdt_count, tb_count;
    logic [2:0]  sp_init;
    int          failures = 0, samples_checked = 0, resets;
    always #2.5 pclk = ~pclk;
    rsi_top dut (.*);
    rsi_core_model core (.pclk(pclk), .presetn(presetn), .core_reset(core_reset),
        .resets(resets));
    task complete_run;
        $display("failures %0d checks %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            failures++;
            $display("unexpected at %0t: no ready from the slave", $time);
            complete_run;
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        `CHK(rd, e)
    endtask
    // one source for n cycles, then let the reset settle
    task ev(input int k, input int n);
        @(posedge pclk);
        if (k == 0) por_req <= 1;
        else if (k == 1) lvr_low <= 1;
        else wdt_overflow <= 1;
        repeat (n) @(posedge pclk);
        por_req <= 0;
        lvr_low <= 0;
        wdt_overflow <= 0;
        repeat (10) @(posedge pclk);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        repeat (3) @(posedge pclk);
        rdc(`RSI_OFF_STATUS, 0);
        rdc(`RSI_OFF_CTRL, 0);
        apb(1, `RSI_OFF_CTRL, 7);
        // pins change on the write edge: look one edge later
        @(posedge pclk);
        `CHK(io_dir_out, 16'hFFFF)
        `CHK({pc_init, sp_init}, 19'h0)
        wdt_clear <= 1;
        @(posedge pclk);
        wdt_clear <= 0;
        @(posedge pclk);
        `CHK(wdt_count, 16'h0000)
        ev(2, 1);
        rdc(`RSI_OFF_STATUS, 1);
        apb(1, `RSI_OFF_CTRL, 7);
        low_power_mode <= 1;
        ev(2, 1);
        rdc(`RSI_OFF_STATUS, 3);
        rdc(`RSI_OFF_CTRL, 7);
        ev(1, 8);
        `CHK(resets, 3)
        low_power_mode <= 0;
        ev(1, 2);
        `CHK(resets, 3)
        apb(1, `RSI_OFF_RFLAG, 0);
        ev(1, 8);
        `CHK(resets, 4)
        rdc(`RSI_OFF_STATUS, 3);
        rdc(`RSI_OFF_RFLAG, 4);
        rdc(`RSI_OFF_IRQ_STAT, 32'hF);
        apb(1, `RSI_OFF_IRQ_MASK, 32'hF);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1, `RSI_OFF_IRQ_STAT, 32'hF);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        // controls on, so the power-on reset has something to clear
        apb(1, `RSI_OFF_CTRL, 7);
        ev(0, 1);
        `CHK(resets, 5)
        rdc(`RSI_OFF_STATUS, 0);
        rdc(`RSI_OFF_CTRL, 0);
        rdc(12'h018, 0);
        `CHK(err, 1'b1)
        complete_run;
    end
endmodule // reset_initial_state_logic_bench
`default_nettype wire
